/* design/lte_drive_monitor.sv */
// Drive monitor: flags a line that stops showing transitions
`timescale 1ns/1ps

module lte_drive_monitor import lte_pkg::*; #(
    parameter int LIMIT = LTE_MON_LIMIT
) (
    input wire logic core_clk,
    input wire logic reset,
    input wire logic tick,
    input wire logic tip,
    input wire logic ring,
    output logic fault
);

    localparam int CW = $clog2(LIMIT) + 1;
    localparam logic [CW-1:0] LAST = CW'(LIMIT - 1);

    typedef struct packed {
        logic tip_prev;
        logic ring_prev;
        logic [CW-1:0] cnt;
        logic fault;
    } lte_mon_s;

    lte_mon_s st_q;
    lte_mon_s st_d;
    logic trans;

    assign trans = (tip != st_q.tip_prev) || (ring != st_q.ring_prev);
    assign fault = st_q.fault;

    always_comb begin
        st_d = st_q;
        if (tick) begin
            st_d.tip_prev = tip;
            st_d.ring_prev = ring;
            if (trans) begin
                st_d.cnt = '0;
                st_d.fault = 1'b0;
            end else if (st_q.cnt == LAST) begin
                st_d.fault = 1'b1;
            end else begin
                st_d.cnt = st_q.cnt + CW'(1);
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    chk_fault_clear: assert property (@(posedge core_clk) disable iff (reset)
        (tick && trans) |=> !fault)
        else $error("drive fault stayed high after a transition");

    chk_fault_set: assert property (@(posedge core_clk) disable iff (reset)
        (tick && !trans && st_q.cnt == LAST) |=> fault)
        else $error("drive fault not raised after silent periods");

endmodule : lte_drive_monitor

/* design/lte_encoder.sv */
// Transmit path: rail selection, zero substitution, line driver control, drive monitor
// Notes on behaviour
// - Single-rail when format pin high, bit0 instead in host mode
// - Dual-rail: both inputs are encoded line data
// - Single-rail uses B3ZS, or HDB3 in E3
// - Three zeros become B0V or 00V
// - Four zeros become 000V or B00V
// - Dual-rail bypasses the zero substitution
// - Dual-rail violations go out as plain pulses
// - Build-out on when level setting low
// - Build-out always off in E3
// - Monitor bit selects own driver as source in host mode
// - Fault low while transitions are seen
// - Fault after 128 silent clocks, clears later
// - Transmitter on: pin, and bit in host mode
// - Transmitter off: line outputs high impedance
//
// Chosen here: the strobed register port and the address map.
`timescale 1ns/1ps

module lte_encoder import lte_pkg::*; #(
    parameter int MON_LIMIT = LTE_MON_LIMIT
) (
    input wire logic core_clk,
    input wire logic reset,
    input wire lte_pins_s pins,
    input wire logic tx_line_clock,
    input wire logic tx_positive_in,
    input wire logic tx_negative_in,
    input wire logic monitor_tip_in,
    input wire logic monitor_ring_in,
    input wire lte_bus_req_s bus,
    output logic [31:0] rd_data,
    output logic line_tip_out,
    output logic line_tip_oe,
    output logic line_ring_out,
    output logic line_ring_oe,
    output logic build_out_en,
    output logic drive_fault_out,
    output logic irq
);

    // ==========================================================
    // State
    typedef struct packed {
        lte_pins_s pin_s1;
        lte_pins_s pin_s2;
        logic [4:0] in_s1;
        logic [4:0] in_s2;
        logic clk_s3;
        logic [7:0] ctrl;
        logic [LTE_IRQ_W-1:0] irq_stat;
        logic [LTE_IRQ_W-1:0] irq_en;
        logic [31:0] rdata;
        lte_ent_s [LTE_PIPE_DEPTH-1:0] pipe;
        logic [2:0] zrun;
        logic par;
        logic last_neg;
        logic tip;
        logic ring;
        logic oe;
        logic build_out;
        logic irq;
        logic fault_prev;
    } lte_st_s;

    lte_st_s st_q;
    lte_st_s st_d;

    // Bit order of the synchronised inputs
    localparam int IN_CLK = 4;
    localparam int IN_POS = 3;
    localparam int IN_NEG = 2;
    localparam int IN_TIP = 1;
    localparam int IN_RING = 0;

    logic tick;
    logic host;
    logic single;
    logic e3;
    logic tx_on;
    logic lev;
    logic internal_mon;
    logic pos;
    logic neg;
    logic [2:0] run_last;
    logic [1:0] run_first;
    logic mon_tip;
    logic mon_ring;
    logic fault;
    logic subst;
    logic [LTE_IRQ_W-1:0] ev;
    logic [LTE_IRQ_W-1:0] clr;
    lte_ent_s ent;
    lte_ent_s head;

    // ==========================================================
    // Mode decode, all from synchronised pins and registers
    assign tick = st_q.in_s2[IN_CLK] & ~st_q.clk_s3;
    assign host = st_q.pin_s2.host_mode;
    assign single = host ? st_q.ctrl[LTE_CTRL_SR_BIT] : st_q.pin_s2.rail_format_select;
    assign e3 = host ? (st_q.ctrl[LTE_CTRL_RATE_LSB +: 2] == LTE_RATE_E3)
                     : (st_q.pin_s2.rate == LTE_RATE_E3);
    // In host mode the bit only hands control to the pin, so both must agree
    assign tx_on = st_q.pin_s2.transmitter_on & (~host | st_q.ctrl[LTE_CTRL_TRANSMITTER_ON_BIT]);
    assign lev = host ? st_q.ctrl[LTE_CTRL_LEV_BIT] : st_q.pin_s2.build_out_level;
    assign internal_mon = host & st_q.ctrl[LTE_CTRL_MON_BIT];
    assign pos = st_q.in_s2[IN_POS];
    assign neg = st_q.in_s2[IN_NEG];
    assign run_last = e3 ? LTE_HDB3_LAST : LTE_B3ZS_LAST;
    assign run_first = e3 ? LTE_HDB3_FIRST_IDX : LTE_B3ZS_FIRST_IDX;
    assign head = st_q.pipe[LTE_PIPE_DEPTH-1];

    // Own driver is watched only while it actually drives the line
    assign mon_tip = internal_mon ? (st_q.tip & st_q.oe) : st_q.in_s2[IN_TIP];
    assign mon_ring = internal_mon ? (st_q.ring & st_q.oe) : st_q.in_s2[IN_RING];

    // ==========================================================
    // Drive monitor
    lte_drive_monitor #(
        .LIMIT(MON_LIMIT)
    ) u_mon (
        .core_clk(core_clk),
        .reset(reset),
        .tick(tick),
        .tip(mon_tip),
        .ring(mon_ring),
        .fault(fault)
    );

    // ==========================================================
    // Next state
    always_comb begin
        st_d = st_q;
        ent = '0;
        subst = 1'b0;
        ev = '0;
        clr = '0;

        st_d.pin_s1 = pins;
        st_d.pin_s2 = st_q.pin_s1;
        st_d.in_s1 = {tx_line_clock, tx_positive_in, tx_negative_in, monitor_tip_in, monitor_ring_in};
        st_d.in_s2 = st_q.in_s1;
        st_d.clk_s3 = st_q.in_s2[IN_CLK];

        st_d.oe = tx_on;
        st_d.build_out = ~e3 & ~lev;

        if (tick) begin
            if (single) begin
                if (pos) begin
                    ent.kind = LTE_SYM_MARK;
                    st_d.zrun = '0;
                    st_d.par = ~st_q.par;
                end else if (st_q.zrun == run_last) begin
                    // Run complete: the newest zero becomes the violation
                    ent.kind = LTE_SYM_VIOL;
                    st_d.zrun = '0;
                    st_d.par = 1'b0;
                    subst = 1'b1;
                end else begin
                    ent.kind = LTE_SYM_ZERO;
                    st_d.zrun = st_q.zrun + 3'h1;
                end
            end else begin
                // Pre-encoded data passes as given, violations included
                ent.kind = (pos | neg) ? LTE_SYM_RAIL : LTE_SYM_ZERO;
                ent.neg = neg & ~pos;
                st_d.zrun = '0;
            end

            // Same depth in every mode keeps output timing fixed
            st_d.pipe = {st_q.pipe[LTE_PIPE_DEPTH-2:0], ent};
            // Even pulse count since the last violation: first zero becomes B
            if (subst && !st_q.par) begin
                st_d.pipe[run_first].kind = LTE_SYM_MARK;
            end

            unique case (head.kind)
                LTE_SYM_MARK: begin
                    st_d.last_neg = ~st_q.last_neg;
                    st_d.tip = st_q.last_neg;
                    st_d.ring = ~st_q.last_neg;
                end
                LTE_SYM_VIOL: begin
                    // Repeats the previous polarity on purpose
                    st_d.tip = ~st_q.last_neg;
                    st_d.ring = st_q.last_neg;
                end
                LTE_SYM_RAIL: begin
                    st_d.last_neg = head.neg;
                    st_d.tip = ~head.neg;
                    st_d.ring = head.neg;
                end
                LTE_SYM_ZERO: begin
                    st_d.tip = 1'b0;
                    st_d.ring = 1'b0;
                end
            endcase
        end

        // Interrupt events
        st_d.fault_prev = fault;
        ev[LTE_IRQ_FAULT_SET] = fault & ~st_q.fault_prev;
        ev[LTE_IRQ_FAULT_CLR] = ~fault & st_q.fault_prev;
        ev[LTE_IRQ_SUBST] = subst;

        // Register writes
        if (bus.wr) begin
            unique case (bus.addr)
                LTE_REG_CTRL: st_d.ctrl = bus.wdata[7:0];
                LTE_REG_IRQ_ENABLE: st_d.irq_en = bus.wdata[LTE_IRQ_W-1:0];
                LTE_REG_IRQ_CLEAR: clr = bus.wdata[LTE_IRQ_W-1:0];
                default: ;
            endcase
        end
        // A new event wins over a clear in the same cycle
        st_d.irq_stat = (st_q.irq_stat & ~clr) | ev;
        st_d.irq = |(st_d.irq_stat & st_d.irq_en);

        // Register reads: data stand for one cycle only
        st_d.rdata = '0;
        if (bus.rd) begin
            unique case (bus.addr)
                LTE_REG_CTRL: st_d.rdata = {24'h000000, st_q.ctrl};
                LTE_REG_STATUS: st_d.rdata = {27'h0000000, e3, single, st_q.build_out, st_q.oe, fault};
                LTE_REG_IRQ_STATUS: st_d.rdata = {29'h00000000, st_q.irq_stat};
                LTE_REG_IRQ_ENABLE: st_d.rdata = {29'h00000000, st_q.irq_en};
                default: st_d.rdata = '0;
            endcase
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            st_q <= '0;
            st_q.ctrl <= LTE_CTRL_RST;
        end else begin
            st_q <= st_d;
        end
    end

    // ==========================================================
    // Outputs
    assign rd_data = st_q.rdata;
    assign line_tip_out = st_q.tip;
    assign line_ring_out = st_q.ring;
    assign line_tip_oe = st_q.oe;
    assign line_ring_oe = st_q.oe;
    assign build_out_en = st_q.build_out;
    assign drive_fault_out = fault;
    assign irq = st_q.irq;

    // ==========================================================
    // Checks
    chk_build_e3_off: assert property (@(posedge core_clk) disable iff (reset)
        e3 |=> !build_out_en)
        else $error("build-out enabled in E3 mode");

    chk_build_level: assert property (@(posedge core_clk) disable iff (reset)
        (!e3 && !lev) |=> build_out_en)
        else $error("build-out not enabled for low level setting");

    chk_transmitter_on_host: assert property (@(posedge core_clk) disable iff (reset)
        (host && !st_q.ctrl[LTE_CTRL_TRANSMITTER_ON_BIT]) |=> !line_tip_oe)
        else $error("transmitter on although host bit is clear");

    chk_tx_off_hiz: assert property (@(posedge core_clk) disable iff (reset)
        !st_q.pin_s2.transmitter_on |=> (!line_tip_oe && !line_ring_oe))
        else $error("line driven while transmitter off");

    chk_dual_bypass: assert property (@(posedge core_clk) disable iff (reset)
        (tick && !single) |=> (st_q.pipe[0].kind != LTE_SYM_VIOL && st_q.pipe[0].kind != LTE_SYM_MARK))
        else $error("substitution symbol in dual-rail mode");

    chk_b3zs_subst: assert property (@(posedge core_clk) disable iff (reset)
        (tick && single && !e3 && !pos && st_q.zrun == 3'h2) |=> st_q.pipe[0].kind == LTE_SYM_VIOL)
        else $error("third zero not replaced by a violation");

    chk_hdb3_b00v: assert property (@(posedge core_clk) disable iff (reset)
        (tick && single && e3 && !pos && st_q.zrun == 3'h3 && !st_q.par)
        |=> (st_q.pipe[0].kind == LTE_SYM_VIOL && st_q.pipe[3].kind == LTE_SYM_MARK))
        else $error("even pulse count not answered with B00V");

    chk_viol_polarity: assert property (@(posedge core_clk) disable iff (reset)
        (tick && head.kind == LTE_SYM_VIOL) |=> (line_ring_out == $past(st_q.last_neg) && line_tip_out != line_ring_out))
        else $error("violation pulse with wrong polarity");

    chk_rail_pass: assert property (@(posedge core_clk) disable iff (reset)
        (tick && head.kind == LTE_SYM_RAIL) |=> (line_ring_out == $past(head.neg) && line_tip_out == !$past(head.neg)))
        else $error("dual-rail pulse not passed through");

    chk_mark_out: assert property (@(posedge core_clk) disable iff (reset)
        (tick && head.kind == LTE_SYM_MARK) |=> (line_tip_out ^ line_ring_out))
        else $error("mark did not leave as a pulse");

endmodule : lte_encoder

/* design/lte_pkg.sv */
// Shared constants and types for the line transmit encoder
package lte_pkg;

    // ==========================================================
    // Register map
    localparam int LTE_ADDR_W = 8;
    localparam int LTE_DATA_W = 32;
    localparam logic [7:0] LTE_REG_CTRL = 8'h00;
    localparam logic [7:0] LTE_REG_STATUS = 8'h04;
    localparam logic [7:0] LTE_REG_IRQ_STATUS = 8'h08;
    localparam logic [7:0] LTE_REG_IRQ_ENABLE = 8'h0c;
    localparam logic [7:0] LTE_REG_IRQ_CLEAR = 8'h10;

    // Control register fields
    localparam int LTE_CTRL_SR_BIT = 0;
    localparam int LTE_CTRL_LEV_BIT = 1;
    localparam int LTE_CTRL_MON_BIT = 2;
    localparam int LTE_CTRL_TRANSMITTER_ON_BIT = 3;
    localparam int LTE_CTRL_RATE_LSB = 4;
    localparam logic [7:0] LTE_CTRL_RST = 8'h00;

    // Interrupt status bits
    localparam int LTE_IRQ_FAULT_SET = 0;
    localparam int LTE_IRQ_FAULT_CLR = 1;
    localparam int LTE_IRQ_SUBST = 2;
    localparam int LTE_IRQ_W = 3;

    // ==========================================================
    // Coding and monitor counts
    localparam int LTE_PIPE_DEPTH = 4;
    localparam logic [2:0] LTE_B3ZS_LAST = 3'h2;
    localparam logic [2:0] LTE_HDB3_LAST = 3'h3;
    localparam logic [1:0] LTE_B3ZS_FIRST_IDX = 2'h2;
    localparam logic [1:0] LTE_HDB3_FIRST_IDX = 2'h3;
    localparam int LTE_MON_LIMIT = 128;

    // ==========================================================
    // Types
    typedef enum logic [1:0] {
        LTE_RATE_DS3 = 2'b00,
        LTE_RATE_STS1 = 2'b01,
        LTE_RATE_E3 = 2'b10
    } lte_rate_e;

    typedef enum logic [1:0] {
        LTE_SYM_ZERO = 2'b00,
        LTE_SYM_MARK = 2'b01,
        LTE_SYM_VIOL = 2'b10,
        LTE_SYM_RAIL = 2'b11
    } lte_sym_e;

    typedef struct packed {
        lte_sym_e kind;
        logic neg;
    } lte_ent_s;

    typedef struct packed {
        logic host_mode;
        logic rail_format_select;
        logic build_out_level;
        logic transmitter_on;
        lte_rate_e rate;
    } lte_pins_s;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [31:0] wdata;
    } lte_bus_req_s;

endpackage : lte_pkg

/* tb/line_transmit_encoder_tb.sv */
// Self-checking bench for the line transmit encoder
`timescale 1ns/1ps

module line_transmit_encoder_tb import lte_pkg::*;;
    logic core_clk = 1'b0;
    logic reset = 1'b1;
    lte_pins_s pins = '0;
    lte_bus_req_s bus = '0;
    logic monitor_tip_in = 1'b0;
    logic monitor_ring_in = 1'b0;
    logic tx_line_clock, tx_positive_in, tx_negative_in, fm_busy;
    logic [31:0] rd_data;
    logic line_tip_out, line_tip_oe, line_ring_out, line_ring_oe, build_out_en, drive_fault_out, irq;
    logic fm_start = 1'b0;
    logic [39:0] fm_pos = '0;
    logic [39:0] fm_neg = '0;
    logic [5:0] fm_n = '0;
    logic [5:0] fm_idx;
    logic [2:0] fm_phase;
    logic mon_follow = 1'b0;
    logic exp_t [40];
    logic exp_r [40];
    logic [31:0] rv;
    int error_cnt = 0;
    int samples_checked = 0;
    int cycle_cnt = 0;
    localparam logic [39:0] PAT_A = 40'h00_8121_0c31;
    localparam logic [39:0] PAT_B = 40'h00_0f18_4921;
    localparam logic [39:0] PAT_ALT = 40'h55_5555_5555;

    always #10 core_clk = ~core_clk;

    lte_encoder #(.MON_LIMIT(8)) uut (.core_clk(core_clk), .reset(reset), .pins(pins),
        .tx_line_clock(tx_line_clock), .tx_positive_in(tx_positive_in), .tx_negative_in(tx_negative_in),
        .monitor_tip_in(monitor_tip_in), .monitor_ring_in(monitor_ring_in), .bus(bus), .rd_data(rd_data),
        .line_tip_out(line_tip_out), .line_tip_oe(line_tip_oe), .line_ring_out(line_ring_out),
        .line_ring_oe(line_ring_oe), .build_out_en(build_out_en), .drive_fault_out(drive_fault_out), .irq(irq));

    lte_framer_model fm (.core_clk(core_clk), .start(fm_start), .pos_word(fm_pos), .neg_word(fm_neg),
        .nbits(fm_n), .tx_line_clock(tx_line_clock), .tx_positive_in(tx_positive_in),
        .tx_negative_in(tx_negative_in), .busy(fm_busy), .idx(fm_idx), .phase(fm_phase));

    // External monitor taps follow the framer rails when asked, else stay silent
    always @(posedge core_clk) begin
        monitor_tip_in <= mon_follow & tx_positive_in;
        monitor_ring_in <= mon_follow & tx_negative_in;
    end

    // ==========================================================
    // Common tasks
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check

    task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk);
        bus <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge core_clk);
        bus.wr <= 1'b0;
    endtask : bus_wr

    task automatic bus_rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge core_clk);
        bus <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0};
        @(posedge core_clk);
        bus.rd <= 1'b0;
        #1;
        d = rd_data;
    endtask : bus_rd

    task automatic set_pins(input logic h, input logic sr, input logic lev, input logic on, input lte_rate_e r);
        @(posedge core_clk);
        pins <= '{host_mode: h, rail_format_select: sr, build_out_level: lev, transmitter_on: on, rate: r};
    endtask : set_pins

    task automatic settle();
        repeat (6) @(posedge core_clk);
        #1;
    endtask : settle

    task automatic do_reset();
        @(posedge core_clk);
        reset <= 1'b1;
        repeat (2) @(posedge core_clk);
        reset <= 1'b0;
        repeat (4) @(posedge core_clk);
    endtask : do_reset

    // Reference zero substitution; after reset the first mark goes out on ring
    task automatic ref_encode(input logic [39:0] d, input int len, input int run);
        int zeros;
        int pulses;
        logic last_neg;
        zeros = 0;
        pulses = 0;
        last_neg = 1'b0;
        for (int i = 0; i < len; i++) begin
            exp_t[i] = 1'b0;
            exp_r[i] = 1'b0;
            zeros = d[i] ? 0 : zeros + 1;
            if (d[i]) begin
                last_neg = ~last_neg;
                pulses++;
                exp_t[i] = ~last_neg;
                exp_r[i] = last_neg;
            end else if (zeros == run) begin
                if (pulses % 2 == 0) begin
                    last_neg = ~last_neg;
                    exp_t[i-run+1] = ~last_neg;
                    exp_r[i-run+1] = last_neg;
                end
                exp_t[i] = ~last_neg;
                exp_r[i] = last_neg;
                pulses = 0;
                zeros = 0;
            end
        end
    endtask : ref_encode

    // Sends n bits plus five fillers; run 0 means raw dual-rail pass-through
    task automatic run_frame(input logic [39:0] pd, input logic [39:0] nd, input int n, input int run);
        if (run != 0) ref_encode(pd, n + 5, run);
        else for (int i = 0; i < n + 5; i++) begin
            exp_t[i] = pd[i];
            exp_r[i] = nd[i] & ~pd[i];
        end
        @(posedge core_clk);
        fm_pos <= pd;
        fm_neg <= nd;
        fm_n <= 6'(n + 5);
        fm_start <= 1'b1;
        @(posedge core_clk);
        fm_start <= 1'b0;
        for (int k = 0; k < n; k++) begin
            do begin
                @(posedge core_clk);
                #1;
            end while (!(fm_idx == 6'(k + 5) && fm_phase == 3'h6));
            check({line_tip_out, line_ring_out}, {exp_t[k], exp_r[k]});
        end
        while (fm_busy === 1'b1) @(posedge core_clk);
        settle();
    endtask : run_frame

    // ==========================================================
    // Scenarios
    task automatic t_regs();
        bus_rd(LTE_REG_CTRL, rv);
        check(rv, 32'h0);
        bus_wr(LTE_REG_CTRL, 32'h2b);
        bus_rd(LTE_REG_CTRL, rv);
        check(rv, 32'h2b);
        bus_rd(8'h20, rv);
        check(rv, 32'h0);
        bus_wr(LTE_REG_CTRL, 32'h0);
        $display("test regs done");
    endtask : t_regs

    task automatic t_ctrl();
        set_pins(0, 0, 0, 1, LTE_RATE_DS3);
        settle();
        check({build_out_en, line_tip_oe, line_ring_oe}, 3'h7);
        set_pins(0, 0, 1, 0, LTE_RATE_STS1);
        settle();
        check({build_out_en, line_tip_oe, line_ring_oe}, 3'h0);
        set_pins(0, 0, 0, 1, LTE_RATE_E3);
        settle();
        check(build_out_en, 1'b0);
        set_pins(1, 0, 1, 1, LTE_RATE_E3);
        bus_wr(LTE_REG_CTRL, 32'h00);
        settle();
        check({build_out_en, line_tip_oe, line_ring_oe}, 3'h4);
        bus_wr(LTE_REG_CTRL, 32'h28);
        settle();
        check({build_out_en, line_tip_oe, line_ring_oe}, 3'h3);
        bus_rd(LTE_REG_STATUS, rv);
        check(rv, 32'h12);
        $display("test ctrl done");
    endtask : t_ctrl

    task automatic t_coding();
        set_pins(0, 1, 0, 1, LTE_RATE_DS3);
        do_reset();
        run_frame(PAT_A, 40'h0, 32, 3);
        bus_rd(LTE_REG_IRQ_STATUS, rv);
        check(rv[LTE_IRQ_SUBST], 1'b1);
        set_pins(0, 1, 0, 1, LTE_RATE_E3);
        do_reset();
        run_frame(PAT_A, 40'h0, 32, 4);
        set_pins(1, 0, 0, 1, LTE_RATE_DS3);
        do_reset();
        bus_wr(LTE_REG_CTRL, 32'h19);
        run_frame(PAT_B, 40'h0, 32, 3);
        bus_wr(LTE_REG_CTRL, 32'h29);
        do_reset();
        bus_wr(LTE_REG_CTRL, 32'h29);
        run_frame(PAT_B, 40'h0, 32, 4);
        set_pins(0, 0, 0, 1, LTE_RATE_DS3);
        do_reset();
        run_frame(PAT_A, 40'h00_1402_0046, 32, 0);
        $display("test coding done");
    endtask : t_coding

    task automatic t_monitor();
        set_pins(0, 0, 0, 1, LTE_RATE_DS3);
        do_reset();
        bus_wr(LTE_REG_IRQ_ENABLE, 32'h1);
        run_frame(PAT_ALT, 40'h0, 12, 0);
        check({drive_fault_out, irq}, 2'h3);
        bus_rd(LTE_REG_IRQ_STATUS, rv);
        check(rv[0], 1'b1);
        bus_wr(LTE_REG_IRQ_CLEAR, 32'h1);
        settle();
        check(irq, 1'b0);
        mon_follow <= 1'b1;
        run_frame(PAT_ALT, 40'h0, 12, 0);
        check(drive_fault_out, 1'b0);
        mon_follow <= 1'b0;
        set_pins(1, 0, 0, 1, LTE_RATE_DS3);
        bus_wr(LTE_REG_CTRL, 32'h0c);
        run_frame(PAT_ALT, 40'h0, 12, 0);
        check(drive_fault_out, 1'b0);
        bus_wr(LTE_REG_CTRL, 32'h08);
        run_frame(PAT_ALT, 40'h0, 12, 0);
        check(drive_fault_out, 1'b1);
        $display("test monitor done");
    endtask : t_monitor

    // ==========================================================
    // Closing report and hang guard
    task automatic print_verdict();
        $display("checks=%0d mismatches=%0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : print_verdict

    always @(posedge core_clk) begin
        cycle_cnt++;
        if (cycle_cnt == 20000) begin
            error_cnt++;
            print_verdict();
        end
    end

    initial begin
        repeat (12) @(posedge core_clk);
        reset <= 1'b0;
        repeat (4) @(posedge core_clk);
        t_regs();
        t_ctrl();
        t_coding();
        t_monitor();
        print_verdict();
    end
endmodule : line_transmit_encoder_tb

/* tb/lte_framer_model.sv */
// Framer model: drives the transmit line clock and rails, one frame at a time
`timescale 1ns/1ps

module lte_framer_model (
    input wire logic core_clk,
    input wire logic start,
    input wire logic [39:0] pos_word,
    input wire logic [39:0] neg_word,
    input wire logic [5:0] nbits,
    output logic tx_line_clock,
    output logic tx_positive_in,
    output logic tx_negative_in,
    output logic busy,
    output logic [5:0] idx,
    output logic [2:0] phase
);
    // ==========================================================
    // Line bit is 8 core cycles, clock high for 3 of them (37.5 percent duty)
    initial begin
        busy = 1'b0;
        idx = 6'h00;
        phase = 3'h0;
        tx_positive_in = 1'b0;
        tx_negative_in = 1'b0;
    end

    // Clock stands low between frames
    assign tx_line_clock = busy && (phase >= 3'h5);

    // Data changes on the same core clock edge as the falling edge, well ahead of the next rise
    always @(posedge core_clk) begin
        if (start) begin
            busy <= 1'b1;
            idx <= 6'h00;
            phase <= 3'h0;
            tx_positive_in <= pos_word[0];
            tx_negative_in <= neg_word[0];
        end else if (busy) begin
            phase <= phase + 3'h1;
            if (phase == 3'h7) begin
                idx <= idx + 6'h01;
                if (idx + 6'h01 == nbits) begin
                    busy <= 1'b0;
                    tx_positive_in <= ~tx_positive_in;
                end else begin
                    tx_positive_in <= pos_word[idx+6'h01];
                    tx_negative_in <= neg_word[idx+6'h01];
                end
            end
        end
    end
endmodule : lte_framer_model
